/* design/flash_pkg.sv */
// Shared constants of the flash register interface and its host end.
// Assumes a single 40 MHz clock and 16-bit peripheral bus words.
package flash_pkg;
  // ==========================================================
  // Peripheral bus map
  localparam logic [23:0] REG_FIRST   = 24'h0E0000;
  localparam logic [23:0] REG_LAST    = 24'h0E0015;
  localparam logic [23:0] ARRAY_LAST  = 24'h08FFFF;
  localparam logic [23:0] TEST_LAST   = 24'h000FFF;
  localparam logic [15:0] TRAP_CODE   = 16'h009B;
  localparam int          NUM_REGS    = 11;
  // Register byte offsets inside the window
  localparam logic [4:0]  OFS_STATUS_LOW = 5'h00;
  localparam logic [4:0]  OFS_CMD_HIGH   = 5'h02;
  localparam logic [4:0]  OFS_SEL_LOW    = 5'h04;
  localparam logic [4:0]  OFS_DATA0_LOW  = 5'h08;
  localparam logic [4:0]  OFS_DATA1_LOW  = 5'h0C;
  localparam logic [4:0]  OFS_ADDR_LOW   = 5'h10;
  localparam logic [4:0]  OFS_ERROR      = 5'h14;
  // Bit positions
  localparam int BIT_NVR_BUSY   = 1;
  localparam int BIT_LOCK       = 4;
  localparam int BIT_BUSY0      = 5;
  localparam int BIT_BANK1      = 6;
  localparam int BIT_SET_PROT   = 8;
  localparam int BIT_START      = 15;
  localparam int BIT_GATE       = 5;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [2:0]  SYNC_RESET = 3'h0;
  // ==========================================================
  // Host register map (AXI4-Lite byte addresses)
  localparam logic [7:0]  HOFS_CTRL   = 8'h00;
  localparam logic [7:0]  HOFS_PCFG   = 8'h04;
  localparam logic [7:0]  HOFS_ADDR   = 8'h08;
  localparam logic [7:0]  HOFS_WDATA  = 8'h0C;
  localparam logic [7:0]  HOFS_STATUS = 8'h10;
  localparam logic [7:0]  HOFS_RDATA  = 8'h14;
  localparam int BIT_GO    = 0;
  localparam int BIT_WRITE = 1;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    HOST_IDLE = 2'b01,
    HOST_WAIT = 2'b10
  } host_state_e;
endpackage

/* design/flash_bus_if.sv */
// Peripheral bus between the CPU-side host and the flash register block.
// Request is held until ack; ack is a one-cycle pulse with rdata.
`timescale 1ns/100ps
`default_nettype none
interface flash_bus_if;
  logic        req;
  logic        wr;
  logic [23:0] addr;
  logic [1:0]  be;
  logic [15:0] wdata;
  logic        gate;
  logic        ack;
  logic [15:0] rdata;
  modport device (input req, wr, addr, be, wdata, gate, output ack, rdata);
  modport host   (output req, wr, addr, be, wdata, gate, input ack, rdata);
endinterface
`default_nettype wire

/* design/flash_ctrl_regs.sv */
// Flash program/erase register interface and busy/lock status logic.
// Assumes the host holds req until ack and the flash core pulses
// op_done / op_suspend on this clock; supply_low and bootstrap are pins.
`timescale 1ns/100ps
`default_nettype none
module flash_ctrl_regs
  import flash_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  flash_bus_if.device      bus,
  input  wire logic        supply_low,
  input  wire logic        bootstrap,
  input  wire logic        op_done,
  input  wire logic        op_suspend,
  input  wire logic [15:0] error_flags,
  input  wire logic [15:0] array_rdata,
  output logic             array_wr,
  output logic [23:0]      array_waddr,
  output logic [15:0]      array_wdata,
  output logic             test_sector_sel,
  output logic             op_start,
  output logic             op_abort,
  output logic [15:0]      op_command,
  output logic [31:0]      sector_select,
  output logic [31:0]      prog_addr,
  output logic [31:0]      prog_data_even,
  output logic [31:0]      prog_data_odd,
  output logic [15:0]      error_reg
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [NUM_REGS-1:0][15:0] regs;
    logic        busy0;
    logic        nvr_busy;
    logic        lock;
    logic [2:0]  sup_sync;
    logic [2:0]  boot_sync;
    logic        sup_low;
    logic        boot;
    logic        ack;
    logic [15:0] rdata;
    logic        array_wr;
    logic [23:0] array_waddr;
    logic [15:0] array_wdata;
    logic        test_sel;
    logic        op_start;
    logic        op_abort;
  } dev_s;

  dev_s s;
  dev_s next_s;

  // ==========================================================
  // Helpers
  function automatic logic in_regs(input logic [23:0] a);
    return (a >= REG_FIRST) && (a <= REG_LAST);
  endfunction

  function automatic logic in_array(input logic [23:0] a);
    return a <= ARRAY_LAST;
  endfunction

  function automatic logic in_test(input logic [23:0] a);
    return a <= TEST_LAST;
  endfunction

  // Byte-lane merge; every writable register honours both lanes
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wd,
                                        input logic [1:0]  be);
    return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic logic [15:0] status_low(input dev_s st);
    logic [15:0] v;
    v = REG_RESET;
    v[BIT_BANK1]    = st.busy0 | st.nvr_busy;
    v[BIT_BUSY0]    = st.busy0;
    v[BIT_LOCK]     = st.lock;
    v[BIT_NVR_BUSY] = st.nvr_busy;
    return v;
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [3:0]  idx;
    logic [15:0] wv;
    idx = bus.addr[4:1];
    wv = REG_RESET;
    next_s = s;
    next_s.ack = 1'b0;
    next_s.array_wr = 1'b0;
    next_s.op_start = 1'b0;
    next_s.op_abort = 1'b0;

    // Pin synchronisers: a change counts once stages 2 and 3 agree
    next_s.sup_sync = {s.sup_sync[1:0], supply_low};
    next_s.boot_sync = {s.boot_sync[1:0], bootstrap};
    if (s.sup_sync[1] == s.sup_sync[2]) begin
      next_s.sup_low = s.sup_sync[2];
    end
    if (s.boot_sync[1] == s.boot_sync[2]) begin
      next_s.boot = s.boot_sync[2];
    end

    // Completion or suspend returns the bank to read mode
    if (op_done || op_suspend) begin
      next_s.busy0 = 1'b0;
      next_s.nvr_busy = 1'b0;
      next_s.lock = 1'b0;
      next_s.regs[OFS_CMD_HIGH[4:1]][BIT_START] = 1'b0;
    end
    // Error flags land only as the busy flags drop
    if (op_done) begin
      next_s.regs[OFS_ERROR[4:1]] = error_flags;
    end

    // Bus access, taken once per held request
    if (bus.req && !s.ack) begin
      next_s.ack = 1'b1;
      next_s.rdata = REG_RESET;
      next_s.test_sel = 1'b0;
      if (in_regs(bus.addr) && bus.gate) begin
        if (s.lock && idx != 4'h0) begin
          next_s.rdata = TRAP_CODE;
        end else if (!bus.wr) begin
          next_s.rdata = (idx == 4'h0) ? status_low(s) : s.regs[idx];
        end else if (idx == 4'h1) begin
          wv = merge(s.regs[idx], bus.wdata, bus.be);
          // Clearing the start bit by software has no effect
          if (wv[BIT_START] && !s.regs[idx][BIT_START]) begin
            next_s.lock = 1'b1;
            next_s.op_start = 1'b1;
            if (wv[BIT_SET_PROT]) begin
              next_s.nvr_busy = 1'b1;
            end else begin
              next_s.busy0 = 1'b1;
            end
          end
          wv[BIT_START] = wv[BIT_START] | s.regs[idx][BIT_START];
          next_s.regs[idx] = wv;
        end else if (idx != 4'h0 && idx != OFS_ERROR[4:1]) begin
          // Status bits are hardware-owned; error register is read-only
          next_s.regs[idx] = merge(s.regs[idx], bus.wdata, bus.be);
        end
      end else if (in_array(bus.addr)) begin
        if (s.busy0 || s.nvr_busy) begin
          next_s.rdata = TRAP_CODE;
        end else if (!bus.wr) begin
          next_s.rdata = array_rdata;
          next_s.test_sel = s.boot && in_test(bus.addr);
        end else if (!in_test(bus.addr)) begin
          next_s.array_wr = 1'b1;
          next_s.array_waddr = bus.addr;
          next_s.array_wdata = bus.wdata;
        end
      end
    end

    // Supply drop during a busy operation wins over everything: abort and back to read mode
    if (next_s.sup_low && (s.busy0 || s.nvr_busy)) begin
      next_s.op_abort = 1'b1;
      next_s.busy0 = 1'b0;
      next_s.nvr_busy = 1'b0;
      next_s.lock = 1'b0;
      next_s.op_start = 1'b0;
      next_s.regs[OFS_CMD_HIGH[4:1]][BIT_START] = 1'b0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  assign bus.ack         = s.ack;
  assign bus.rdata       = s.rdata;
  assign array_wr        = s.array_wr;
  assign array_waddr     = s.array_waddr;
  assign array_wdata     = s.array_wdata;
  assign test_sector_sel = s.test_sel;
  assign op_start        = s.op_start;
  assign op_abort        = s.op_abort;
  assign op_command      = s.regs[OFS_CMD_HIGH[4:1]];
  assign sector_select   = {s.regs[3], s.regs[OFS_SEL_LOW[4:1]]};
  assign prog_data_even  = {s.regs[5], s.regs[OFS_DATA0_LOW[4:1]]};
  assign prog_data_odd   = {s.regs[7], s.regs[OFS_DATA1_LOW[4:1]]};
  assign prog_addr       = {s.regs[9], s.regs[OFS_ADDR_LOW[4:1]]};
  assign error_reg       = s.regs[OFS_ERROR[4:1]];

endmodule // flash_ctrl_regs
`default_nettype wire

/* design/flash_host.sv */
// CPU-side end: AXI4-Lite slave that issues one peripheral bus access
// per command and owns the peripheral configuration gate bit.
// Assumes one AXI write and one read outstanding at most.
`timescale 1ns/100ps
`default_nettype none
module flash_host
  import flash_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  flash_bus_if.host        bus
);

  // ==========================================================
  // State
  typedef struct packed {
    logic        aw_taken;
    logic        w_taken;
    logic [3:0]  strb;
    logic [7:0]  waddr;
    logic [31:0] wd;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rd;
    logic [15:0] pcfg;
    logic        req;
    logic        wr;
    logic [1:0]  be;
    logic [23:0] addr;
    logic [15:0] bus_wdata;
    logic [15:0] bus_rdata;
    host_state_e state;
  } host_s;

  host_s s;
  host_s next_s;

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [7:0]  wa;
    logic [31:0] wv;
    logic [3:0]  ws;
    wa = s.aw_taken ? s.waddr : awaddr;
    wv = s.w_taken ? s.wd : wdata;
    // Strobes travel with their data word, which may arrive before the address
    ws = s.w_taken ? s.strb : wstrb;
    next_s = s;
    if (awvalid && awready) begin
      next_s.aw_taken = 1'b1;
      next_s.waddr = awaddr;
    end
    if (wvalid && wready) begin
      next_s.w_taken = 1'b1;
      next_s.wd = wdata;
      next_s.strb = wstrb;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end

    // Peripheral access completes on ack; software must not start
    // a register write while the device lock bit is set
    if (s.state == HOST_WAIT && bus.ack) begin
      next_s.req = 1'b0;
      next_s.state = HOST_IDLE;
      if (!s.wr) begin
        next_s.bus_rdata = bus.rdata;
      end
    end

    // Write executes once address and data are both in
    if ((s.aw_taken || (awvalid && awready)) && (s.w_taken || (wvalid && wready))) begin
      next_s.aw_taken = 1'b0;
      next_s.w_taken = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      unique case (wa)
        HOFS_CTRL: begin
          if (wv[BIT_GO] && s.state == HOST_IDLE) begin
            next_s.req = 1'b1;
            next_s.wr = wv[BIT_WRITE];
            next_s.be = wv[3:2];
            next_s.state = HOST_WAIT;
          end
        end
        HOFS_PCFG: begin
          if (ws[0]) begin
            next_s.pcfg[7:0] = wv[7:0];
          end
          if (ws[1]) begin
            next_s.pcfg[15:8] = wv[15:8];
          end
        end
        HOFS_ADDR:  next_s.addr = (s.state == HOST_IDLE) ? wv[23:0] : s.addr;
        HOFS_WDATA: next_s.bus_wdata = (s.state == HOST_IDLE) ? wv[15:0] : s.bus_wdata;
        default:    next_s.bresp = RESP_SLVERR;
      endcase
    end

    // Read answers one cycle after the address is taken
    if (arvalid && arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rd = 32'h0000_0000;
      unique case (araddr)
        HOFS_CTRL:   next_s.rd = {28'h0000000, s.be, s.wr, 1'b0};
        HOFS_PCFG:   next_s.rd = {16'h0000, s.pcfg};
        HOFS_ADDR:   next_s.rd = {8'h00, s.addr};
        HOFS_WDATA:  next_s.rd = {16'h0000, s.bus_wdata};
        HOFS_STATUS: next_s.rd = {31'h00000000, s.state == HOST_WAIT};
        HOFS_RDATA:  next_s.rd = {16'h0000, s.bus_rdata};
        default:     next_s.rresp = RESP_SLVERR;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '{state: HOST_IDLE, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs; channel readies stall while a response is pending
  assign awready   = !s.aw_taken && !s.bvalid;
  assign wready    = !s.w_taken && !s.bvalid;
  assign bvalid    = s.bvalid;
  assign bresp     = s.bresp;
  assign arready   = !s.rvalid;
  assign rvalid    = s.rvalid;
  assign rresp     = s.rresp;
  assign rdata     = s.rd;
  assign bus.req   = s.req;
  assign bus.wr    = s.wr;
  assign bus.addr  = s.addr;
  assign bus.be    = s.be;
  assign bus.wdata = s.bus_wdata;
  assign bus.gate  = s.pcfg[BIT_GATE];

endmodule // flash_host
`default_nettype wire

/* test/flash_bus_properties.sv */
// Checker for the peripheral bus between the host end and the flash registers.
// Assumes it is instantiated beside the interface with its signals as inputs.
`timescale 1ns/100ps
`default_nettype none
module flash_bus_properties
  import flash_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        req,
  input wire logic        wr,
  input wire logic [23:0] addr,
  input wire logic [1:0]  be,
  input wire logic [15:0] wdata,
  input wire logic        gate,
  input wire logic        ack,
  input wire logic [15:0] rdata
);
  // ==========================================================
  // Handshake and read data
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic rd_ack;
  // Read answers only; write acks carry zero, or the trap code when refused
  assign rd_ack = ack && !wr;
  a_ack_next_cycle: assert property (req && !ack |=> ack)
    else $error("ack not one cycle after request");
  a_ack_single_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_ack_inside_req: assert property (ack |-> req)
    else $error("ack without request");
  a_req_stays_put: assert property (req && !ack |=> req && $stable(addr) && $stable(wdata))
    else $error("request changed before ack");
  a_gate_off_zero: assert property (rd_ack && !$past(gate) && addr > ARRAY_LAST
    |-> rdata == 16'h0000)
    else $error("gated read not zero");
  a_window_end_zero: assert property (rd_ack && addr > REG_LAST && addr[23:16] == 8'h0E
    |-> rdata == 16'h0000)
    else $error("read outside window not zero");
  a_reserved_bits_zero: assert property (rd_ack && addr == REG_FIRST && be == 2'b11
    |-> (rdata & 16'hFF8D) == 16'h0000)
    else $error("reserved status bit set");
  a_bank1_mirror: assert property (rd_ack && addr == REG_FIRST && be == 2'b11
    |-> rdata[BIT_BANK1] == (rdata[BIT_BUSY0] | rdata[BIT_NVR_BUSY]))
    else $error("bank1 mirror wrong");
  // Main scenarios reached
  c_write_ack: cover property (ack && wr);
  c_trap_read: cover property (rd_ack && rdata == TRAP_CODE);
  c_lock_seen: cover property (rd_ack && addr == REG_FIRST && rdata[BIT_LOCK]);
endmodule // flash_bus_properties
`default_nettype wire

/* test/tb_flash_write_status_interface.sv */
// Testbench for host end and flash register end joined by the bus interface.
// Assumes the flash core is emulated by pulses driven from here.
`timescale 1ns/100ps
`default_nettype none
module tb_flash_write_status_interface
  import flash_pkg::*;
;
  // ==========================================================
  // Signals
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0]  wstrb = 4'hF;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        supply_low = 1'b0, bootstrap = 1'b0, op_done = 1'b0, op_suspend = 1'b0;
  logic [15:0] error_flags = 16'h0005;
  logic [15:0] array_rdata = 16'hC3C3;
  logic        array_wr, test_sector_sel, op_start, op_abort;
  logic [23:0] array_waddr;
  logic [15:0] array_wdata, op_command, error_reg;
  logic [31:0] prog_addr, prog_data_even;
  int          n_errors = 0, checks = 0, n_start = 0, n_abort = 0, n_awr = 0;
  logic [31:0] v;
  logic [1:0]  r;
  logic [15:0] q;
  typedef struct {logic [23:0] a; logic [15:0] d; logic [1:0] be; logic [15:0] e;} row_s;
  row_s rows [0:5] = '{'{24'h0E0008, 16'h1234, 2'h3, 16'h1234},
                       '{24'h0E000A, 16'hABCD, 2'h3, 16'hABCD},
                       '{24'h0E000A, 16'h1100, 2'h2, 16'h11CD},
                       '{24'h0E0010, 16'h5A5A, 2'h1, 16'h005A},
                       '{24'h0E0016, 16'hFFFF, 2'h3, 16'h0000},
                       '{24'h0E0000, 16'hFFFF, 2'h3, 16'h0000}};
  // Half period of 12.5 ns gives 40 MHz
  always #12.5 aclk = ~aclk;
  // ==========================================================
  // Both ends and the checker
  flash_bus_if flash_bus_if_inst ();
  flash_host flash_host_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .bus(flash_bus_if_inst));
  flash_ctrl_regs flash_ctrl_regs_inst (.aclk, .aresetn, .bus(flash_bus_if_inst), .supply_low,
    .bootstrap, .op_done, .op_suspend, .error_flags, .array_rdata, .array_wr,
    .array_waddr, .array_wdata, .test_sector_sel, .op_start, .op_abort, .op_command,
    .sector_select(), .prog_addr, .prog_data_even, .prog_data_odd(), .error_reg);
  flash_bus_properties flash_bus_properties_inst (.aclk, .aresetn,
    .req(flash_bus_if_inst.req), .wr(flash_bus_if_inst.wr), .addr(flash_bus_if_inst.addr),
    .be(flash_bus_if_inst.be), .wdata(flash_bus_if_inst.wdata), .gate(flash_bus_if_inst.gate),
    .ack(flash_bus_if_inst.ack), .rdata(flash_bus_if_inst.rdata));
  // Count core pulses; running totals from time zero are compared, never reset
  always @(posedge aclk) begin
    if (op_start === 1'b1) n_start++;
    if (op_abort === 1'b1) n_abort++;
    if (array_wr === 1'b1) n_awr++;
  end
  // ==========================================================
  // Tasks
  task automatic chk16(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // One peripheral bus access via the host; busy is polled, then the read data is fetched
  // Only the watchdog ends a poll that never sees the access finish
  task automatic bus(input logic [23:0] a, input logic w, input logic [1:0] be,
                     input logic [15:0] d, output logic [15:0] rd);
    logic [31:0] s;
    logic [1:0]  rs;
    axi_wr(HOFS_ADDR, {8'h00, a});
    axi_wr(HOFS_WDATA, {16'h0000, d});
    axi_wr(HOFS_CTRL, {28'h0000000, be, w, 1'b1});
    do begin
      axi_rd(HOFS_STATUS, s, rs);
    end while (s[0] !== 1'b0);
    axi_rd(HOFS_RDATA, s, rs);
    rd = s[15:0];
  endtask
  task automatic rd_chk(input string nm, input logic [23:0] a, input logic [15:0] exp);
    bus(a, 1'b0, 2'h3, 16'h0000, q);
    chk16(nm, exp, q);
  endtask
  task automatic core_pulse(input logic sus);
    @(posedge aclk);
    op_suspend <= sus;
    op_done <= !sus;
    @(posedge aclk);
    op_suspend <= 1'b0;
    op_done <= 1'b0;
  endtask
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence: table first, then the awkward cases
  initial begin
    do_reset();
    axi_wr(HOFS_PCFG, 32'h00000020);
    foreach (rows[i]) begin
      bus(rows[i].a, 1'b1, rows[i].be, rows[i].d, q);
      rd_chk("table readback", rows[i].a, rows[i].e);
    end
    chk16("data even high", 16'h11CD, prog_data_even[31:16]);
    chk16("address low", 16'h005A, prog_addr[15:0]);
    $display("test table done");
    rd_chk("idle array read", 24'h001000, 16'hC3C3);
    bus(24'h000100, 1'b1, 2'h3, 16'h0F0F, q);
    chk16("test sector write", 16'h0000, 16'(n_awr));
    bus(24'h010000, 1'b1, 2'h3, 16'h0F0F, q);
    chk16("array write", 16'h0001, 16'(n_awr));
    chk16("array write addr", 16'h0100, array_waddr[23:8]);
    chk16("array write data", 16'h0F0F, array_wdata);
    // Start a write; lock and busy must trap registers and array
    bus(24'h0E0002, 1'b1, 2'h3, 16'h8000, q);
    chk16("start pulses", 16'h0001, 16'(n_start));
    rd_chk("status busy", REG_FIRST, 16'h0070);
    rd_chk("locked reg", 24'h0E0008, TRAP_CODE);
    // Data register write while locked; it must be discarded
    bus(24'h0E0008, 1'b1, 2'h3, 16'h4444, q);
    rd_chk("busy array read", 24'h001000, TRAP_CODE);
    bus(24'h010000, 1'b1, 2'h3, 16'h0F0F, q);
    chk16("busy array write", 16'h0001, 16'(n_awr));
    core_pulse(1'b0);
    rd_chk("status done", REG_FIRST, 16'h0000);
    rd_chk("error reg", 24'h0E0014, 16'h0005);
    chk16("error out", 16'h0005, error_reg);
    chk16("start bit cleared", 16'h0000, op_command);
    rd_chk("locked write lost", 24'h0E0008, 16'h1234);
    $display("test write done");
    // Protection register write, suspend, then resume and supply drop
    bus(24'h0E0002, 1'b1, 2'h3, 16'h8100, q);
    rd_chk("status protect", REG_FIRST, 16'h0052);
    rd_chk("protect array read", 24'h001000, TRAP_CODE);
    core_pulse(1'b1);
    rd_chk("status suspended", REG_FIRST, 16'h0000);
    bus(24'h0E0002, 1'b1, 2'h3, 16'h8000, q);
    rd_chk("status resumed", REG_FIRST, 16'h0070);
    supply_low <= 1'b1;
    repeat (16) @(posedge aclk);
    supply_low <= 1'b0;
    chk16("abort pulses", 16'h0001, 16'(n_abort));
    rd_chk("status aborted", REG_FIRST, 16'h0000);
    $display("test protect and abort done");
    bootstrap <= 1'b1;
    repeat (4) @(posedge aclk);
    bus(24'h000100, 1'b0, 2'h3, 16'h0000, q);
    chk16("test sector visible", 16'h0001, {15'h0000, test_sector_sel});
    do_reset();
    axi_rd(HOFS_PCFG, v, r);
    chk16("gate after reset", 16'h0000, v[15:0]);
    rd_chk("gated read", 24'h0E0008, 16'h0000);
    axi_rd(8'h20, v, r);
    chk16("unmapped host resp", {14'h0000, RESP_SLVERR}, {14'h0000, r});
    $display("test reset and gate done");
    tally_and_finish();
  end
  // Watchdog: the whole sequence needs well under 20000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    tally_and_finish();
  end
endmodule // tb_flash_write_status_interface
`default_nettype wire
